// ==== hw/grs_edge_if.sv ====
// interface carrying synchronised encode edge events between modules
`timescale 1ns/1ns
interface grs_edge_if;
    import grs_pkg::*;
    logic enc_level;
    logic rise;
    logic fall;
    modport src (output enc_level, output rise, output fall);
    modport dst (input enc_level, input rise, input fall);
endinterface : grs_edge_if

// ==== hw/grs_enc_sync.sv ====
// encode pin synchroniser and edge detector
`timescale 1ns/1ns
module grs_enc_sync
    import grs_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic encode,
    grs_edge_if.src ev
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } grs_sync_s;

    grs_sync_s st_r;
    grs_sync_s st_nxt;

    // three stages; a change counts while stages two and three differ
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = encode;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // s1 is never read here, only by s2
    assign ev.enc_level = st_r.s3;
    assign ev.rise = st_r.s2 & ~st_r.s3;
    assign ev.fall = ~st_r.s2 & st_r.s3;
endmodule : grs_enc_sync

// ==== hw/grs_pkg.sv ====
// constants and types shared by the gain ranging sample sequencer
// Overview of operation
// - while encode is high the peak detector tracks the input, both signs.
// - an encode fall latches the peak and sets that input's attenuator.
// - that same fall enables the gain stage and puts the hold in track.
// - the next encode rise puts the track-and-hold in hold.
// - the next fall converts the held value onto the data outputs.
// - each word carries its gain code: 11-bit mantissa, 3-bit exponent.
// - select pins at binary 10 sample input A on every encode cycle.
// - select pins at binary 11 alternate A and B, halving each rate.
// - a clamp discharges the external filter network between samples.
// - a tripped peak comparator stays set until the next encode fall.
// - five comparators 6 dB apart are encoded into a 3-bit gain code.
// - gain-code changes carry 6 dB of hysteresis against toggling.
package grs_pkg;
    localparam int GRS_MANT_W = 11;
    localparam int GRS_EXP_W = 3;
    localparam int GRS_CMP_N = 5;
    localparam logic [1:0] GRS_SEL_A_ONLY = 2'h2;
    localparam logic [1:0] GRS_SEL_ALT = 2'h3;
    localparam logic [2:0] GRS_CODE_MAX = 3'h5;
    localparam logic [2:0] GRS_CODE_RST = 3'h0;
    localparam logic [10:0] GRS_MANT_RST = 11'h000;
    localparam logic [4:0] GRS_TRIP_RST = 5'h00;

    // encode edge events seen by the sequencer
    typedef enum logic [1:0] {GRS_ENC_IDLE, GRS_ENC_RISE, GRS_ENC_FALL}
        grs_edge_e;

    // thermometer of tripped comparators to a gain code: one per 6 dB
    function automatic logic [2:0] grs_therm_code(input logic [4:0] t);
        logic [2:0] c;
        c = 3'h0;
        for (int i = 0; i < GRS_CMP_N; i++)
        begin
            if (t[i])
                c = 3'(i + 1);
        end
        return c;
    endfunction : grs_therm_code
endpackage : grs_pkg

// ==== hw/grs_sequencer.sv ====
// gain ranging sample sequencer top
`timescale 1ns/1ns
module grs_sequencer
    import grs_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic encode,
    input wire logic [1:0] input_sel,
    input wire logic [4:0] peak_trip,
    input wire logic [10:0] conv_word,
    output logic peak_track_en,
    output logic peak_clear,
    output logic [2:0] atten_a,
    output logic [2:0] atten_b,
    output logic chan_b_sel,
    output logic gain_en,
    output logic th_track,
    output logic conv_start,
    output logic filter_clamp,
    output logic [10:0] data_out,
    output logic [2:0] gain_exp,
    output logic data_chan_b,
    output logic data_valid
);
    grs_edge_if ev ();

    grs_enc_sync u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .encode(encode),
        .ev(ev)
    );

    typedef struct packed {
        logic [4:0] trip;
        logic [2:0] code_a;
        logic [2:0] code_b;
        logic chan_b;
        logic [2:0] held_code;
        logic held_chan_b;
        logic held_ok;
        logic gain_en;
        logic th_track;
        logic conv;
        logic [10:0] data;
        logic [2:0] exp;
        logic data_b;
        logic valid;
        logic [1:0] sel;
    } grs_state_s;

    grs_state_s st_r;
    grs_state_s st_nxt;

    // hysteresis: rise at once, fall only when 12 dB or more below the present range
    function automatic logic [2:0] grs_hyst(input logic [2:0] cur,
        input logic [2:0] raw);
        logic [2:0] r;
        r = cur;
        if (raw > cur)
            r = raw;
        else if (raw + 3'h1 < cur)
            r = raw + 3'h1;
        return r;
    endfunction : grs_hyst

    // sequencing on encode edges seen through the synchroniser
    always_comb
    begin
        logic [2:0] raw;
        logic [2:0] code;
        raw = grs_therm_code(st_r.trip);
        code = 3'h0;
        st_nxt = st_r;
        st_nxt.conv = 1'b0;
        st_nxt.valid = 1'b0;
        st_nxt.sel = input_sel;
        // comparators latch while encode is high, both polarities
        if (ev.enc_level && !ev.fall)
            st_nxt.trip = st_r.trip | peak_trip;
        if (ev.rise)
        begin
            st_nxt.th_track = 1'b0;
            st_nxt.held_ok = st_r.gain_en;
        end
        if (ev.fall)
        begin
            st_nxt.trip = GRS_TRIP_RST;
            if (st_r.chan_b)
            begin
                code = grs_hyst(st_r.code_b, raw);
                st_nxt.code_b = code;
            end
            else
            begin
                code = grs_hyst(st_r.code_a, raw);
                st_nxt.code_a = code;
            end
            st_nxt.held_code = code;
            st_nxt.held_chan_b = st_r.chan_b;
            st_nxt.gain_en = 1'b1;
            st_nxt.th_track = 1'b1;
            // previously held sample converts now, with its own code
            if (st_r.held_ok)
            begin
                st_nxt.conv = 1'b1;
                st_nxt.data = conv_word;
                st_nxt.exp = st_r.held_code;
                st_nxt.data_b = st_r.held_chan_b;
                st_nxt.valid = 1'b1;
            end
            // next channel depends on the select mode and the present channel
            if (st_r.sel == GRS_SEL_ALT)
                st_nxt.chan_b = ~st_r.chan_b;
            else
                st_nxt.chan_b = 1'b0;
        end
        if (sys_rst)
            st_nxt.sel = GRS_SEL_A_ONLY;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
            st_r.code_a <= GRS_CODE_RST;
            st_r.code_b <= GRS_CODE_RST;
            st_r.data <= GRS_MANT_RST;
            st_r.sel <= GRS_SEL_A_ONLY;
        end
        else
            st_r <= st_nxt;
    end

    // analog controls; clamp whenever the track-and-hold is not tracking
    assign peak_track_en = ev.enc_level;
    assign peak_clear = ev.fall;
    assign atten_a = st_r.code_a;
    assign atten_b = st_r.code_b;
    assign chan_b_sel = st_r.chan_b;
    assign gain_en = st_r.gain_en;
    assign th_track = st_r.th_track;
    assign conv_start = st_r.conv;
    assign filter_clamp = ~st_r.th_track;
    assign data_out = st_r.data;
    assign gain_exp = st_r.exp;
    assign data_chan_b = st_r.data_b;
    assign data_valid = st_r.valid;
endmodule : grs_sequencer

// ==== verif/gain_ranging_sample_sequencer_test.sv ====
// self-checking bench for the sample sequencer
`timescale 1ns/1ns
module gain_ranging_sample_sequencer_test
    import grs_pkg::*;
;
    logic clk = 1'h0, sys_rst = 1'h1, encode = 1'h0, data_chan_b, data_valid;
    logic [1:0] input_sel = GRS_SEL_A_ONLY;
    logic [4:0] peak_trip = 5'h00;
    logic [10:0] conv_word = 11'h000, data_out;
    logic [2:0] gain_exp, raw, pcode, cur [2];
    logic pch, ch;
    logic [14:0] got, want, q [$];
    int errors = 0, n_checks = 0, seed = 7, k = 0;
    logic signed [15:0] rx_word;
    logic [15:0] rx_want;
    logic rx_due = 1'h0;
    // 50 ns clock
    always #25 clk = ~clk;
    grs_sequencer u_dut (.clk, .sys_rst, .encode, .input_sel, .peak_trip,
        .conv_word, .peak_track_en(), .peak_clear(), .atten_a(), .atten_b(),
        .chan_b_sel(), .gain_en(), .th_track(), .conv_start(),
        .filter_clamp(), .data_out, .gain_exp, .data_chan_b, .data_valid);
    grs_rx_model u_rx (.clk, .data_valid, .data_out, .gain_exp, .rx_word);
    task automatic check(input logic [15:0] g, input logic [15:0] w);
        n_checks++;
        if (g !== w)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, g, w);
        end
    endtask : check
    // drain, then restart in a new mode; a leftover note is a lost word
    task automatic do_reset(input logic [1:0] mode);
        repeat (6) @(posedge clk);
        check(16'(q.size()), 16'h0000);
        sys_rst <= 1'h1;
        input_sel <= mode;
        repeat (4) @(posedge clk);
        sys_rst <= 1'h0;
        k = 0;
        cur = '{3'h0, 3'h0};
        repeat (4) @(posedge clk);
    endtask : do_reset
    // trips and word change at the rise, while the design still sees low
    task automatic enc_cycle();
        @(posedge clk);
        encode <= 1'h1;
        peak_trip <= 5'($random(seed));
        conv_word <= 11'($random(seed));
        repeat (5) @(posedge clk);
        encode <= 1'h0;
        raw = 3'h0;
        for (int i = 0; i < 5; i++)
            if (peak_trip[i])
                raw = 3'(i + 1);
        ch = (input_sel == GRS_SEL_ALT) && k[0];
        if (raw > cur[ch] || raw + 3'h2 <= cur[ch])
            cur[ch] = (raw > cur[ch]) ? raw : raw + 3'h1;
        if (k > 0)
            q.push_back({conv_word, pcode, pch});
        pcode = cur[ch];
        pch = ch;
        k++;
        repeat (4) @(posedge clk);
    endtask : enc_cycle
    // each word is matched against the oldest note
    // the receiver's fixed-point word follows one clock after each word
    always @(posedge clk)
    begin
        if (rx_due)
            check(rx_word, rx_want);
        rx_due = 1'h0;
        if (data_valid === 1'h1)
        begin
            got = {data_out, gain_exp, data_chan_b};
            want = (q.size() > 0) ? q.pop_front() : 15'hx;
            check(16'(got), 16'(want));
            // sign-extended mantissa scaled up by the gain code
            rx_want = {{5{want[14]}}, want[14:4]} << want[3:1];
            rx_due = 1'h1;
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    // a-only run, alternating run, final drain
    initial
    begin
        do_reset(GRS_SEL_A_ONLY);
        repeat (24) enc_cycle();
        do_reset(GRS_SEL_ALT);
        repeat (24) enc_cycle();
        do_reset(GRS_SEL_A_ONLY);
        tally_and_finish();
    end
    // the run needs about 530 clocks
    initial
    begin
        repeat (3000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
endmodule : gain_ranging_sample_sequencer_test

// ==== verif/grs_asserts.sv ====
// port assertions for the sequencer
`timescale 1ns/1ns
module grs_asserts
    import grs_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic peak_track_en,
    input wire logic peak_clear,
    input wire logic th_track,
    input wire logic filter_clamp,
    input wire logic data_chan_b,
    input wire logic data_valid,
    input wire logic chan_b_sel,
    input wire logic gain_en,
    input wire logic conv_start,
    input wire logic [1:0] input_sel,
    input wire logic [2:0] atten_a,
    input wire logic [2:0] atten_b,
    input wire logic [10:0] conv_word,
    input wire logic [10:0] data_out
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // timing of track, hold and clamp around the encode edges
    a_clamp_in_hold: assert property (
        $rose(filter_clamp) |-> $past(!peak_track_en) && peak_track_en)
        else $error("clamp on");
    a_clamp_release: assert property (
        $fell(filter_clamp) |-> $past(peak_clear)) else $error("clamp off");
    a_track_on_fall: assert property (
        peak_clear |=> th_track) else $error("no track");
    a_gain_on_fall: assert property (
        peak_clear |=> gain_en) else $error("no gain");
    a_hold_on_rise: assert property (
        $rose(peak_track_en) |-> ##[1:2] !th_track) else $error("no hold");
    // words come one cycle after the fall event that converts them
    a_word_capture: assert property (
        data_valid |-> data_out == $past(conv_word)) else $error("word");
    a_conv_pulse: assert property (
        conv_start |-> data_valid && $past(peak_clear)) else $error("conv");
    a_word_timing: assert property (
        data_valid |-> $past(peak_clear)) else $error("late word");
    // each attenuator moves only on a fall that acquired its own channel
    a_atten_cause: assert property (
        $changed(atten_a) |-> $past(peak_clear) && !$past(chan_b_sel))
        else $error("atten a");
    a_atten_b_cause: assert property (
        $changed(atten_b) |-> $past(peak_clear) && $past(chan_b_sel))
        else $error("atten b");
    a_a_only_words: assert property (
        data_valid && input_sel == GRS_SEL_A_ONLY |-> !data_chan_b)
        else $error("b word");
    // the word out belongs to the channel that is acquired next
    a_alt_order: assert property (
        data_valid && input_sel == GRS_SEL_ALT |-> data_chan_b == chan_b_sel)
        else $error("order");
endmodule : grs_asserts
bind grs_sequencer grs_asserts u_chk (.clk, .sys_rst, .peak_track_en,
    .peak_clear, .th_track, .filter_clamp, .data_chan_b, .data_valid,
    .chan_b_sel, .gain_en, .conv_start, .input_sel, .atten_a, .atten_b,
    .conv_word, .data_out);

// ==== verif/grs_rx_model.sv ====
// far side model: receiver rebuilding fixed point words
`timescale 1ns/1ns
module grs_rx_model
    import grs_pkg::*;
(
    input wire logic clk,
    input wire logic data_valid,
    input wire logic [10:0] data_out,
    input wire logic [2:0] gain_exp,
    output logic signed [15:0] rx_word
);
    // arithmetic shift keeps the sign on small ranges
    always_ff @(posedge clk)
        if (data_valid)
            rx_word <= $signed({data_out, 5'h00}) >>>
                (GRS_CODE_MAX - gain_exp);
endmodule : grs_rx_model
